// file: hw/dsp_debug_status_power_trace.sv
// Purpose: Debug status, debug resets, low-power debug handling and trace capture
// Assumes: Debug port accesses arrive on sys_clk; power-up requests are async levels
// Notes:   Trace SRAM is shared with the system bus through an AHB-Lite port
// Contract
// [RQ1] Retention-exit flag held until acknowledge write
// [RQ2] Status bits 11-15, 19-31 read zero
// [RQ3] Status bit 16 shows core halted
// [RQ4] Status bit 17 shows core deep sleep
// [RQ5] Status bit 18 shows core core_flag_a
// [RQ6] Power-on reset resets all debug logic
// [RQ7] System reset held while debugger holds bit
// [RQ8] Software reset request generates system reset
// [RQ9] Core reset held while debugger holds bit
// [RQ10] Trace records flow changes into SRAM region
// [RQ11] Trace stores only flow-change addresses
// [RQ12] Bus masters reach whole SRAM during trace
// [RQ13] Trace write wins SRAM contention
// [RQ14] Watchpoint start/stop signals gate trace
// [RQ15] Static debug logic resumes after mode exit
// [RQ16] Powered-off debug logic reset on recovery
// [RQ17] Power-up requests mark debugger active
// [RQ18] Active debugger keeps core clock in stop
// [RQ19] Kept clock: core registers yes, memory no
// [RQ20] Run to low-power stop becomes stop with debug
// [RQ21] Retention entry resets controls; optional recovery hold
// [RQ22] Secure: status read and erase only
// [RQ23] Status bit 3 shows system out of reset
// [RQ24] Very-low-power status bit tracks mode live
// [RQ25] Status register is read-only
`timescale 1ns/1ps
module dsp_debug_status_power_trace (
   input  wire logic                  sys_clk,               // System clock, 10 MHz
   input  wire logic                  rst,                   // Power-on reset, active high
   input  wire dsp_pkg::dsp_dap_req_t dap_req,               // Debugger register request
   output dsp_pkg::dsp_dap_rsp_t      dap_rsp,               // Debugger register answer
   input  wire logic                  flash_secure,          // Flash security active
   input  wire logic                  mass_erase_done,       // Flash finished mass erase
   output logic                       mass_erase_req,        // Mass erase request to flash
   input  wire logic                  core_halted,           // Core in debug halt
   input  wire logic                  core_deep_sleep_flag,  // Core deep sleep indication
   input  wire logic                  core_flag_a,           // Core core_flag_a indication
   input  wire logic                  vlp_mode_active,       // Very-low-power mode in effect
   input  wire logic                  sys_in_reset,          // System currently in reset
   input  wire logic                  system_reset_request,  // Software reset request pulse
   output logic                       sys_reset_out,         // Hold system in reset
   output logic                       core_reset_out,        // Hold core in reset
   input  wire logic                  dbg_pwrup_req_async,   // Debug power-up request pin
   input  wire logic                  sys_pwrup_req_async,   // System power-up request pin
   input  wire logic                  pm_req,                // Stop-mode entry request pulse
   input  wire dsp_pkg::dsp_pm_t      pm_target,             // Requested stop flavour
   input  wire logic                  pm_from_lp_run,        // Request made from low-power run
   output logic                       pm_grant_valid,        // Granted mode valid pulse
   output dsp_pkg::dsp_pm_t           pm_grant_mode,         // Granted stop flavour
   output logic                       core_free_clock_en,    // Keep core clock running
   output logic                       xbar_dbg_block,        // Block debug memory access
   input  wire logic                  vlls_entry,            // Entering retention mode pulse
   input  wire logic                  vlls_recover,          // Recovery from retention pulse
   input  wire logic                  trace_start_signal,    // Watchpoint trace start pulse
   input  wire logic                  trace_stop_signal,     // Watchpoint trace stop pulse
   input  wire dsp_pkg::dsp_trc_pkt_t trc_pkt,               // Core flow-change packet
   input  wire logic [5:0]            trace_base_idx,        // Trace region first word
   input  wire logic [5:0]            trace_limit_idx,       // Trace region last word
   input  wire logic                  hsel,                  // AHB-Lite select
   input  wire logic [31:0]           haddr,                 // AHB-Lite address
   input  wire logic [1:0]            htrans,                // AHB-Lite transfer type
   input  wire logic                  hwrite,                // AHB-Lite write
   input  wire logic                  hready,                // AHB-Lite ready in
   input  wire logic [31:0]           hwdata,                // AHB-Lite write data
   output logic      [31:0]           hrdata,                // AHB-Lite read data
   output logic                       hreadyout,             // AHB-Lite ready out
   output logic                       hresp                  // AHB-Lite response
);
   typedef struct packed {
      logic                  mass_erase;
      logic                  sys_reset;
      logic                  core_reset;
      logic                  vlls_hold;
      logic                  trace_en;
      logic                  vlls_exit;
      logic                  recov_hold;
      logic [4:0]            rst_cnt;
      logic                  trace_active;
      logic                  pend_valid;
      logic [31:0]           pend_word;
      logic [5:0]            wr_idx;
      dsp_pkg::dsp_dap_rsp_t rsp;
      logic                  dbg_active;
      logic                  clk_keep;
      logic                  pm_valid;
      dsp_pkg::dsp_pm_t      pm_mode;
   } dsp_top_st_t;

   dsp_top_st_t          s_q;
   dsp_top_st_t          s_d;
   logic [31:0]          status_w;
   logic [31:0]          control_w;
   logic [1:0]           pwrup_s;
   dsp_pkg::dsp_trc_wr_t trc_wr;

   // Power-up request pins cross into sys_clk
   dsp_sync #(
      .W (2)
   ) u_pwrup_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .d       ({dbg_pwrup_req_async, sys_pwrup_req_async}),
      .q       (pwrup_s)
   );

   // Status image; everything not listed reads zero
   always_comb begin
      status_w                        = 32'h0000_0000; // RQ2
      status_w[dsp_pkg::ST_SECURE]    = flash_secure;
      status_w[dsp_pkg::ST_SYS_NRST]  = ~sys_in_reset; // RQ23
      status_w[dsp_pkg::ST_VLP]       = vlp_mode_active; // RQ24
      status_w[dsp_pkg::ST_VLLS_EXIT] = s_q.vlls_exit; // RQ1
      status_w[dsp_pkg::ST_HALTED]    = core_halted; // RQ3
      status_w[dsp_pkg::ST_DEEP]      = core_deep_sleep_flag; // RQ4
      status_w[dsp_pkg::ST_CORE_FLAG_A]  = core_flag_a; // RQ5
   end

   // Control image; the acknowledge bit reads zero
   always_comb begin
      control_w                         = dsp_pkg::CTL_RESET;
      control_w[dsp_pkg::CT_MASS_ERASE] = s_q.mass_erase;
      control_w[dsp_pkg::CT_SYS_RESET]  = s_q.sys_reset;
      control_w[dsp_pkg::CT_CORE_RESET] = s_q.core_reset;
      control_w[dsp_pkg::CT_VLLS_HOLD]  = s_q.vlls_hold;
      control_w[dsp_pkg::CT_TRACE_EN]   = s_q.trace_en;
   end

   // Trace word to the SRAM: pending destination first, then a new source
   always_comb begin
      trc_wr = '0;
      if (s_q.pend_valid) begin
         trc_wr.valid = 1'b1;
         trc_wr.idx   = s_q.wr_idx;
         trc_wr.data  = s_q.pend_word;
      end else if (trc_pkt.valid && s_q.trace_active) begin
         trc_wr.valid = 1'b1; // RQ10
         trc_wr.idx   = s_q.wr_idx;
         trc_wr.data  = trc_pkt.src; // RQ11
      end
   end

   // Next state for all control and status
   always_comb begin
      s_d           = s_q;
      s_d.rsp.ack   = 1'b0;
      s_d.rsp.err   = 1'b0;
      s_d.rsp.rdata = 32'h0000_0000;
      s_d.pm_valid  = 1'b0;

      // Debugger register access
      if (dap_req.req) begin
         s_d.rsp.ack = 1'b1;
         if (dap_req.sel == dsp_pkg::SEL_STATUS) begin
            if (dap_req.wr) begin
               s_d.rsp.err = 1'b1; // RQ25
            end else begin
               s_d.rsp.rdata = status_w; // RQ22
            end
         end else if (flash_secure) begin
            if (dap_req.wr) begin
               s_d.mass_erase = dap_req.wdata[dsp_pkg::CT_MASS_ERASE]; // RQ22
            end
            s_d.rsp.err = 1'b1; // RQ22
         end else if (dap_req.wr) begin
            s_d.mass_erase = dap_req.wdata[dsp_pkg::CT_MASS_ERASE];
            s_d.sys_reset  = dap_req.wdata[dsp_pkg::CT_SYS_RESET]; // RQ7
            s_d.core_reset = dap_req.wdata[dsp_pkg::CT_CORE_RESET]; // RQ9
            s_d.vlls_hold  = dap_req.wdata[dsp_pkg::CT_VLLS_HOLD];
            s_d.trace_en   = dap_req.wdata[dsp_pkg::CT_TRACE_EN];
            if (!dap_req.wdata[dsp_pkg::CT_VLLS_HOLD]) begin
               s_d.recov_hold = 1'b0; // RQ21
            end
            if (dap_req.wdata[dsp_pkg::CT_VLLS_ACK]) begin
               s_d.vlls_exit = 1'b0; // RQ1
            end
            if (dap_req.wdata[dsp_pkg::CT_TRACE_EN] && !s_q.trace_en) begin
               s_d.wr_idx = trace_base_idx;
            end
         end else begin
            s_d.rsp.rdata = control_w;
         end
      end

      // Flash takes down the erase request when done
      if (mass_erase_done) begin
         s_d.mass_erase = 1'b0;
      end

      // Software reset request stretches into a fixed reset pulse
      if (system_reset_request && s_q.rst_cnt == 5'h00) begin
         s_d.rst_cnt = dsp_pkg::SYSRST_CYCLES; // RQ8
      end else if (s_q.rst_cnt != 5'h00) begin
         s_d.rst_cnt = s_q.rst_cnt - 5'h01;
      end

      // Trace start and stop from the watchpoint unit
      if (trace_start_signal && s_q.trace_en) begin
         s_d.trace_active = 1'b1; // RQ14
      end
      if (trace_stop_signal || !s_d.trace_en) begin
         s_d.trace_active = 1'b0; // RQ14
      end

      // Trace pointer walks the region and wraps at its limit
      if (trc_wr.valid) begin
         s_d.wr_idx = (s_q.wr_idx == trace_limit_idx) ? trace_base_idx : s_q.wr_idx + 6'h01;
         s_d.pend_valid = ~s_q.pend_valid;
         if (!s_q.pend_valid) begin
            s_d.pend_word = trc_pkt.dst; // RQ11
         end
      end

      // Debugger presence may change only outside deep sleep
      if (!core_deep_sleep_flag) begin
         s_d.dbg_active = |pwrup_s; // RQ17
      end

      // Stop-mode requests, with demotion and clock keeping
      if (pm_req) begin
         s_d.pm_valid = 1'b1;
         s_d.pm_mode  = pm_target;
         if (pm_target == dsp_pkg::PM_LPS && !pm_from_lp_run && s_q.dbg_active) begin
            s_d.pm_mode = dsp_pkg::PM_STOP; // RQ20
         end
         if (pm_target != dsp_pkg::PM_VLLS && s_q.dbg_active) begin
            s_d.clk_keep = 1'b1; // RQ18
         end
      end else if (!core_flag_a) begin
         s_d.clk_keep = 1'b0;
      end

      // Retention entry wipes debug controls except vlls_hold; logic held static keeps state
      if (vlls_entry) begin
         s_d.mass_erase   = 1'b0; // RQ21
         s_d.sys_reset    = 1'b0;
         s_d.core_reset   = 1'b0;
         s_d.trace_en     = 1'b0;
         s_d.trace_active = 1'b0;
         s_d.pend_valid   = 1'b0;
         s_d.clk_keep     = 1'b0; // RQ16
      end
      if (vlls_recover) begin
         s_d.vlls_exit  = 1'b1; // RQ1
         s_d.recov_hold = s_q.vlls_hold; // RQ21
      end
   end

   // State register; power-on reset clears everything
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0; // RQ6
      end else begin
         s_q <= s_d; // RQ15
      end
   end

   // Outputs
   assign dap_rsp            = s_q.rsp;
   assign mass_erase_req     = s_q.mass_erase;
   assign sys_reset_out      = s_q.sys_reset | s_q.recov_hold | (s_q.rst_cnt != 5'h00); // RQ7
   assign core_reset_out     = s_q.core_reset; // RQ9
   assign pm_grant_valid     = s_q.pm_valid;
   assign pm_grant_mode      = s_q.pm_mode;
   assign core_free_clock_en = s_q.clk_keep; // RQ18
   assign xbar_dbg_block     = s_q.clk_keep | flash_secure; // RQ19

   // Trace SRAM and its system bus port
   dsp_trace_sram u_sram (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .trc_wr    (trc_wr),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hwdata    (hwdata),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp)
   );

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_status_read;
      dap_req.req && !dap_req.wr && dap_req.sel == dsp_pkg::SEL_STATUS;
   endsequence

   sequence s_sw_reset;
      system_reset_request && s_q.rst_cnt == 5'h00;
   endsequence

   sequence s_ctl_write;
      dap_req.req && dap_req.wr && dap_req.sel == dsp_pkg::SEL_CONTROL && !flash_secure;
   endsequence

   a_status_rsvd_zero: assert property (s_status_read |=> // RQ2
      dap_rsp.ack && dap_rsp.rdata[15:11] == 5'h00 && dap_rsp.rdata[31:19] == 13'h0000)
      else $error("reserved status bits not zero");

   a_status_core_bits: assert property (s_status_read |=> // RQ3
      dap_rsp.rdata[18:16] == {$past(core_flag_a), $past(core_deep_sleep_flag),
                               $past(core_halted)})
      else $error("core status bits wrong");

   a_status_nrst_bit: assert property (s_status_read |=> // RQ23
      dap_rsp.rdata[3] == !$past(sys_in_reset) && dap_rsp.rdata[8] == $past(vlp_mode_active))
      else $error("reset or vlp status bit wrong");

   a_vlls_exit_sticky: assert property (s_q.vlls_exit && !(dap_req.req && dap_req.wr) // RQ1
      |=> s_q.vlls_exit)
      else $error("retention exit flag dropped");

   a_sysreq_pulse: assert property (s_sw_reset |=> sys_reset_out [*8]) // RQ8
      else $error("software reset pulse too short");

   a_core_hold: assert property (s_ctl_write ##0 dap_req.wdata[dsp_pkg::CT_CORE_RESET] // RQ9
      && !vlls_entry |=> core_reset_out)
      else $error("core not held in reset");

   a_trace_stop: assert property (trace_stop_signal |=> !s_q.trace_active) // RQ14
      else $error("trace not stopped");

   a_lps_demote: assert property (pm_req && pm_target == dsp_pkg::PM_LPS // RQ20
      && !pm_from_lp_run && s_q.dbg_active
      |=> pm_grant_valid && pm_grant_mode == dsp_pkg::PM_STOP)
      else $error("run to very_low_power_stop not demoted");

   a_clk_keep: assert property (pm_req && pm_target != dsp_pkg::PM_VLLS && s_q.dbg_active // RQ18
      && !vlls_entry |=> core_free_clock_en && xbar_dbg_block)
      else $error("core clock not kept for debugger");

   a_secure_refuse: assert property (dap_req.req && dap_req.sel == dsp_pkg::SEL_CONTROL // RQ22
      && flash_secure |=> dap_rsp.err && !$changed(s_q.sys_reset) && !$changed(s_q.trace_en))
      else $error("secure control access not refused");

   a_trace_pair: assert property (trc_wr.valid && !s_q.pend_valid && !vlls_entry // RQ10
      |=> trc_wr.valid && trc_wr.data == $past(trc_pkt.dst))
      else $error("trace destination word missing");
endmodule

// file: hw/dsp_pkg.sv
// Purpose: Shared constants and carriers for the debug status, power and trace block
// Assumes: One clock domain; debug port accesses already brought onto sys_clk
// Notes:   Register images are 32 bits; unused bits read as zero
package dsp_pkg;
   // Debug port register selects
   localparam logic SEL_STATUS  = 1'h0;
   localparam logic SEL_CONTROL = 1'h1;

   // Status register bit positions
   localparam int unsigned ST_SECURE    = 2;
   localparam int unsigned ST_SYS_NRST  = 3;
   localparam int unsigned ST_VLP       = 8;
   localparam int unsigned ST_VLLS_EXIT = 10;
   localparam int unsigned ST_HALTED    = 16;
   localparam int unsigned ST_DEEP      = 17;
   localparam int unsigned ST_CORE_FLAG_A  = 18;

   // Control register bit positions
   localparam int unsigned CT_MASS_ERASE = 0;
   localparam int unsigned CT_SYS_RESET  = 3;
   localparam int unsigned CT_CORE_RESET = 4;
   localparam int unsigned CT_VLLS_ACK   = 5;
   localparam int unsigned CT_VLLS_HOLD  = 6;
   localparam int unsigned CT_TRACE_EN   = 8;
   localparam logic [31:0] CTL_RESET     = 32'h0000_0000;

   // Stretch of a software system reset request, in cycles
   localparam logic [4:0] SYSRST_CYCLES = 5'h10;

   // Trace SRAM geometry and AHB-Lite codes
   localparam int unsigned SRAM_AW     = 6;
   localparam int unsigned SRAM_DEPTH  = 64;
   localparam logic [1:0]  HTRANS_IDLE = 2'h0;

   // Requested low-power stop flavour
   typedef enum logic [1:0] {PM_STOP, PM_LPS, PM_VLLS} dsp_pm_t;

   typedef struct packed {
      logic        req;
      logic        wr;
      logic        sel;
      logic [31:0] wdata;
   } dsp_dap_req_t;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } dsp_dap_rsp_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] src;
      logic [31:0] dst;
   } dsp_trc_pkt_t;

   typedef struct packed {
      logic               valid;
      logic [SRAM_AW-1:0] idx;
      logic [31:0]        data;
   } dsp_trc_wr_t;
endpackage

// file: hw/dsp_sync.sv
// Purpose: Two-stage synchroniser for level inputs from another domain
// Assumes: Inputs are levels that stay stable for several cycles
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
module dsp_sync #(
   parameter int unsigned W = 2
) (
   input  wire logic         sys_clk, // System clock
   input  wire logic         rst,     // Async reset, active high
   input  wire logic [W-1:0] d,       // Asynchronous levels
   output logic      [W-1:0] q        // Synchronised levels
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dsp_sync_st_t;

   dsp_sync_st_t s_q;
   dsp_sync_st_t s_d;

   // Shift through two stages
   always_comb begin
      s_d    = s_q;
      s_d.s1 = d;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.s2;
endmodule

// file: hw/dsp_trace_sram.sv
// Purpose: Trace SRAM with AHB-Lite slave port and trace write priority
// Assumes: Word accesses only; HSIZE and byte lanes are not decoded
// Notes:   A trace write in a bus data phase stalls the bus one cycle
`timescale 1ns/1ps
module dsp_trace_sram (
   input  wire logic                 sys_clk,   // System clock
   input  wire logic                 rst,       // Async reset, active high
   input  wire dsp_pkg::dsp_trc_wr_t trc_wr,    // Trace word write
   input  wire logic                 hsel,      // AHB-Lite select
   input  wire logic [31:0]          haddr,     // AHB-Lite address
   input  wire logic [1:0]           htrans,    // AHB-Lite transfer type
   input  wire logic                 hwrite,    // AHB-Lite write
   input  wire logic                 hready,    // AHB-Lite ready in
   input  wire logic [31:0]          hwdata,    // AHB-Lite write data
   output logic      [31:0]          hrdata,    // AHB-Lite read data
   output logic                      hreadyout, // AHB-Lite ready out
   output logic                      hresp      // AHB-Lite response
);
   typedef struct packed {
      logic [dsp_pkg::SRAM_DEPTH-1:0][31:0] mem;
      logic                                 ph_valid;
      logic                                 ph_write;
      logic [dsp_pkg::SRAM_AW-1:0]          ph_idx;
   } dsp_sram_st_t;

   dsp_sram_st_t s_q;
   dsp_sram_st_t s_d;

   // Trace wins the array; the bus data phase waits
   assign hreadyout = ~(s_q.ph_valid & trc_wr.valid); // RQ13
   assign hresp     = 1'b0;
   assign hrdata    = s_q.mem[s_q.ph_idx];

   // Array update, data phase completion, address phase capture
   always_comb begin
      s_d = s_q;
      if (trc_wr.valid) begin
         s_d.mem[trc_wr.idx] = trc_wr.data; // RQ10
      end
      if (s_q.ph_valid && !trc_wr.valid) begin
         if (s_q.ph_write) begin
            s_d.mem[s_q.ph_idx] = hwdata; // RQ12
         end
         s_d.ph_valid = 1'b0;
      end
      if (hreadyout && hsel && hready && htrans != dsp_pkg::HTRANS_IDLE && htrans[1]) begin
         s_d.ph_valid = 1'b1;
         s_d.ph_write = hwrite;
         s_d.ph_idx   = haddr[dsp_pkg::SRAM_AW+1:2];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   a_trace_word_lands: assert property (@(posedge sys_clk) disable iff (rst) // RQ13
      trc_wr.valid |=> s_q.mem[$past(trc_wr.idx)] == $past(trc_wr.data))
      else $error("trace word not stored");
endmodule

// file: tb/dsp_probe.sv
// Purpose: Debugger probe model on the debug register port
// Assumes: Port runs on sys_clk; one access at a time
// Notes:   Released fields show their inverse so stale values never look valid
`timescale 1ns/1ps
module dsp_probe (
   input  wire logic                  sys_clk,   // System clock
   output dsp_pkg::dsp_dap_req_t      dap_req,   // Request to device
   input  wire dsp_pkg::dsp_dap_rsp_t dap_rsp,   // Answer from device
   output logic                       dbg_pwrup, // Debug power-up request
   output logic                       sys_pwrup  // System power-up request
);
   // Power-up requests raised once, at time zero while power-on reset is still held
   initial begin
      dap_req = '0;
      dbg_pwrup = 1'b1;
      sys_pwrup = 1'b1;
   end
   // Request held over the taking edge, answer taken in the next cycle
   task automatic access(input logic wr, input logic sel, input logic [31:0] wd,
                         output logic [31:0] rd, output logic err, output logic ack);
      @(negedge sys_clk);
      dap_req = '{req: 1'b1, wr: wr, sel: sel, wdata: wd};
      @(negedge sys_clk);
      {ack, err, rd} = dap_rsp;
      dap_req = '{req: 1'b0, wr: ~wr, sel: ~sel, wdata: ~wd};
   endtask
endmodule

// file: tb/dsp_debug_status_power_trace_bench.sv
// Purpose: Self-checking bench for debug status, resets, power and trace
// Assumes: Inputs change on falling edges; probe model owns the debug port
// Notes:   Trace region is words 4 to 7
`timescale 1ns/1ps
module dsp_debug_status_power_trace_bench;
   localparam logic S = dsp_pkg::SEL_STATUS;
   localparam logic C = dsp_pkg::SEL_CONTROL;
   dsp_pkg::dsp_dap_req_t dap_req;
   dsp_pkg::dsp_dap_rsp_t dap_rsp;
   dsp_pkg::dsp_trc_pkt_t trc_pkt;
   dsp_pkg::dsp_pm_t      pm_target, pm_grant_mode;
   logic [31:0]           haddr, hwdata, hrdata, rd;
   logic [5:0]            trace_base_idx, trace_limit_idx;
   logic [1:0]            htrans;
   logic sys_clk, rst, flash_secure, mass_erase_done, mass_erase_req, core_halted, vlls_entry;
   logic core_deep_sleep_flag, core_flag_a, vlp_mode_active, sys_in_reset, system_reset_request;
   logic sys_reset_out, core_reset_out, dbg_pwrup_req_async, sys_pwrup_req_async, pm_req;
   logic pm_from_lp_run, pm_grant_valid, core_free_clock_en, xbar_dbg_block, vlls_recover;
   logic trace_start_signal, trace_stop_signal, hsel, hwrite, hready, hreadyout, hresp;
   int   fail_count, num_checks, n;

   dsp_debug_status_power_trace i_dut (.sys_clk, .rst, .dap_req, .dap_rsp, .flash_secure,
      .mass_erase_done, .mass_erase_req, .core_halted, .core_deep_sleep_flag, .core_flag_a,
      .vlp_mode_active, .sys_in_reset, .system_reset_request, .sys_reset_out, .core_reset_out,
      .dbg_pwrup_req_async, .sys_pwrup_req_async, .pm_req, .pm_target, .pm_from_lp_run,
      .pm_grant_valid, .pm_grant_mode, .core_free_clock_en, .xbar_dbg_block, .vlls_entry,
      .vlls_recover, .trace_start_signal, .trace_stop_signal, .trc_pkt, .trace_base_idx,
      .trace_limit_idx, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hrdata,
      .hreadyout, .hresp);
   dsp_probe i_probe (.sys_clk, .dap_req, .dap_rsp, .dbg_pwrup(dbg_pwrup_req_async),
      .sys_pwrup(sys_pwrup_req_async));

   // 10 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic tk(input int c);
      repeat (c) @(negedge sys_clk);
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Register access with answer and error check
   task automatic debug_access_port(input logic wr, input logic sel, input logic [31:0] wd, input logic xe);
      logic a;
      logic e;
      i_probe.access(wr, sel, wd, rd, e, a);
      chk({a, e}, {1'b1, xe});
      tk(1);
   endtask
   // Single AHB-Lite word transfer, read data checked in its data phase
   task automatic ahb(input logic w, input logic [5:0] i, input logic [31:0] d);
      {hsel, htrans, hwrite, haddr} = {1'b1, 2'h2, w, 24'h0, i, 2'h0};
      tk(1);
      {hsel, htrans, hwdata} = {1'b0, dsp_pkg::HTRANS_IDLE, d};
      if (!w) chk({hreadyout, hresp, hrdata}, {2'h2, d});
      tk(1);
   endtask
   task automatic stop_test();
      if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Main sequence
   initial begin
      {fail_count, num_checks} = '0;
      {flash_secure, mass_erase_done, vlls_entry, vlls_recover, system_reset_request, pm_req,
       pm_from_lp_run, trace_start_signal, trace_stop_signal, hsel, hwrite, core_deep_sleep_flag,
       sys_in_reset} = '0;
      {rst, hready, core_halted, core_flag_a, vlp_mode_active} = '1;
      {trc_pkt, haddr, hwdata, htrans} = '0;
      pm_target = dsp_pkg::PM_STOP;
      {trace_base_idx, trace_limit_idx} = {6'h04, 6'h07};
      tk(8);
      rst = 1'b0;
      debug_access_port(1'b0, S, '0, 1'b0);
      chk(rd, 32'h0005_0108);
      {core_halted, core_deep_sleep_flag, sys_in_reset, vlp_mode_active} = 4'h6;
      debug_access_port(1'b0, S, '0, 1'b0);
      chk(rd, 32'h0006_0000);
      {core_deep_sleep_flag, sys_in_reset} = 2'h0;
      debug_access_port(1'b1, S, '1, 1'b1);
      debug_access_port(1'b1, C, 32'h18, 1'b0);
      chk({sys_reset_out, core_reset_out}, 2'h3);
      debug_access_port(1'b1, C, 32'h0, 1'b0);
      chk({sys_reset_out, core_reset_out}, 2'h0);
      system_reset_request = 1'b1;
      tk(1);
      system_reset_request = 1'b0;
      n = 0;
      for (int k = 0; k < 40; k++) begin
         if (sys_reset_out === 1'b1) n++;
         tk(1);
      end
      chk(n, 16);
      // Retention exit flag, acknowledge and recovery hold
      vlls_recover = 1'b1;
      tk(1);
      vlls_recover = 1'b0;
      debug_access_port(1'b0, S, '0, 1'b0);
      chk(rd[10], 1'b1);
      debug_access_port(1'b1, C, 32'h20, 1'b0);
      debug_access_port(1'b0, S, '0, 1'b0);
      chk(rd[10], 1'b0);
      debug_access_port(1'b1, C, 32'h50, 1'b0);
      vlls_entry = 1'b1;
      tk(1);
      {vlls_entry, vlls_recover} = 2'h1;
      tk(1);
      vlls_recover = 1'b0;
      tk(2);
      chk({sys_reset_out, core_reset_out}, 2'h2);
      debug_access_port(1'b1, C, 32'h20, 1'b0);
      chk(sys_reset_out, 1'b0);
      // Stop requests with an active debugger, from run and from low-power run
      for (int v = 0; v < 2; v++) begin
         {pm_req, pm_from_lp_run} = {1'b1, v[0]};
         pm_target = dsp_pkg::PM_LPS;
         tk(1);
         pm_req = 1'b0;
         chk({pm_grant_valid, pm_grant_mode},
             {1'b1, v[0] ? dsp_pkg::PM_LPS : dsp_pkg::PM_STOP});
         tk(1);
         chk({core_free_clock_en, xbar_dbg_block}, 2'h3);
      end
      core_flag_a = 1'b0;
      tk(2);
      chk({core_free_clock_en, xbar_dbg_block}, 2'h0);
      flash_secure = 1'b1;
      debug_access_port(1'b0, C, '0, 1'b1);
      chk(rd, '0);
      debug_access_port(1'b0, S, '0, 1'b0);
      chk({rd[2], xbar_dbg_block}, 2'h3);
      debug_access_port(1'b1, C, 32'h19, 1'b1);
      chk({mass_erase_req, sys_reset_out, core_reset_out}, 3'h4);
      mass_erase_done = 1'b1;
      tk(1);
      mass_erase_done = 1'b0;
      chk(mass_erase_req, 1'b0);
      flash_secure = 1'b0;
      // Trace started and stopped by watchpoint, one flow change before the stop and one after, then bus access
      debug_access_port(1'b1, C, 32'h100, 1'b0);
      trace_start_signal = 1'b1;
      tk(1);
      trace_start_signal = 1'b0;
      trc_pkt = '{1'b1, 32'h1234_5678, 32'h9abc_def0};
      tk(1);
      trc_pkt = '{1'b0, 32'hedcb_a987, 32'h6543_210f};
      tk(3);
      trace_stop_signal = 1'b1;
      tk(1);
      {trace_stop_signal, trc_pkt.valid} = 2'h1;
      tk(1);
      trc_pkt.valid = 1'b0;
      tk(2);
      ahb(1'b0, 6'h06, '0);
      ahb(1'b1, 6'h09, 32'h5a5a_0009);
      ahb(1'b0, 6'h04, 32'h1234_5678);
      ahb(1'b0, 6'h05, 32'h9abc_def0);
      ahb(1'b0, 6'h09, 32'h5a5a_0009);
      stop_test();
   end
endmodule
